// ===== pkg/cmwd_map.svh
// register map and timing constants for the clock mode and watchdog block
// assumes inclusion by bare name from design files
`ifndef CMWD_MAP_SVH
`define CMWD_MAP_SVH
`define CMWD_ADDR_CTRL      12'h000
`define CMWD_ADDR_CORE      12'h004
`define CMWD_ADDR_MASK      12'h008
`define CMWD_ADDR_CMD       12'h00c
`define CMWD_ADDR_STATUS    12'h010
`define CMWD_CTRL_RESET     8'h00
`define CMWD_CORE_RESET     8'hff
`define CMWD_MASK_RESET     8'h00
`define CMWD_BIT_WDT_EN     0
`define CMWD_BIT_CLKSEL_LO  3
`define CMWD_BIT_CLKSEL_HI  5
`define CMWD_BIT_PLL_EN     6
`define CMWD_BIT_TOP        7
`define CMWD_BIT_PSR_HI     2
`define CMWD_BIT_PAB        3
`define CMWD_BIT_PORT70_EDGE_SELECT      7
`define CMWD_BIT_MASK_P70   3
`define CMWD_BIT_MASK_P71   4
`define CMWD_BIT_MASK_P73   7
`define CMWD_BIT_CMD_CLEAR  0
`define CMWD_BIT_CMD_SLEEP  1
`define CMWD_WDT_PERIOD_US  18000
`define CMWD_RC_KHZ         1
`define CMWD_PLL_LOCK_US    2000
`define CMWD_CLK_MHZ        10
`define CMWD_SYNC_SETTLE    2'h3
`endif

// ===== pkg/cmwd_pkg.sv
// types for the clock mode and watchdog block
// assumes nothing else
package cmwd_pkg;
  typedef enum logic [1:0] {
    CMWD_OSC_CRYSTAL = 2'h0,
    CMWD_OSC_IRC     = 2'h1,
    CMWD_OSC_ERC     = 2'h2
  } cmwd_osc_t;

  typedef enum logic [1:0] {
    CMWD_CPU_SUB  = 2'h0,
    CMWD_CPU_LOW  = 2'h1,
    CMWD_CPU_HIGH = 2'h2
  } cmwd_cpu_clk_t;

  typedef enum logic [1:0] {
    CMWD_SW_GREEN = 2'h0,
    CMWD_SW_WAIT  = 2'h1,
    CMWD_SW_NORM  = 2'h3
  } cmwd_sw_state_t;

  typedef struct packed {
    logic p70;
    logic p71;
    logic p73;
  } cmwd_wake_pins_t;
endpackage

// ===== logic/cmwd_sync.sv
// two flip-flop synchroniser, one per bit
// assumes inputs asynchronous to clk_sys_in
`timescale 1ns/1ns
`default_nettype none
module cmwd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  if (WIDTH < 1) begin : g_bad_width
    $error("width must be positive");
  end
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;
  always_comb begin
    next_stage1 = rst_n_in ? async_in : '0;
    next_sync   = rst_n_in ? stage1 : '0;
  end
  always_ff @(posedge clk_sys_in) begin
    stage1   <= next_stage1;
    sync_out <= next_sync;
  end
endmodule // cmwd_sync
`default_nettype wire

// ===== logic/cmwd_wdt.sv
// watchdog counter with optional 1:1..1:128 prescale
// assumes rc_tick_in is a synchronised one-cycle pulse per rc period
`timescale 1ns/1ns
`default_nettype none
`include "cmwd_map.svh"
module cmwd_wdt #(
  parameter int CNT_W    = 16,
  parameter int TIMEOUT  = 18
) (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic       enable_in,
  input  wire logic       clear_in,
  input  wire logic       rc_tick_in,
  input  wire logic       pab_in,
  input  wire logic [2:0] psr_in,
  output logic            expire_out
);
  if (TIMEOUT < 1 || TIMEOUT >= (1 << CNT_W)) begin : g_bad_timeout
    $error("watchdog timeout does not fit");
  end
  logic [7:0]       pre;
  logic [CNT_W-1:0] cnt;
  logic [7:0]       next_pre;
  logic [CNT_W-1:0] next_cnt;
  logic             next_expire;
  logic             step;
  logic [7:0]       pre_top;
  always_comb begin
    pre_top     = 8'((9'h1 << psr_in) - 9'h1);
    step        = rc_tick_in && (!pab_in || pre == pre_top);
    next_pre    = pre;
    next_cnt    = cnt;
    next_expire = 1'b0;
    if (!rst_n_in || clear_in || !enable_in) begin
      next_pre = 8'h00;
      next_cnt = '0;
    end else if (rc_tick_in) begin
      next_pre = (pab_in && pre != pre_top) ? 8'(pre + 8'h01) : 8'h00;
      if (step) begin
        if (cnt == CNT_W'(TIMEOUT - 1)) begin
          next_cnt    = '0;
          next_expire = 1'b1;
        end else begin
          next_cnt = CNT_W'(cnt + 1'b1);
        end
      end
    end
  end
  always_ff @(posedge clk_sys_in) begin
    pre        <= next_pre;
    cnt        <= next_cnt;
    expire_out <= next_expire;
  end
endmodule // cmwd_wdt
`default_nettype wire

// ===== logic/cmwd_top.sv
// clock mode selection, pll power, watchdog and sleep wake-up control
// assumes apb master on clk_sys_in; rc clock and wake pins are asynchronous
// Operation
// - control bit 0 stops watchdog when clear, lets it count when set
// - clear instruction returns watchdog counter to its start value
// - watchdog counts on its own rc oscillator, also during sleep
// - enabled watchdog expiry resets device, awake or asleep
// - software may toggle watchdog enable at any time in either mode
// - unprescaled watchdog expires about 18 ms after clearing
// - main clock select bits act only in crystal mode
// - with pll on, top select bit picks 3.582 MHz or 14.3 MHz
// - with pll off, cpu runs from 32768 Hz sub clock
// - setting pll power bit enters high-frequency mode from pll clock
// - pll power bit acts only in crystal mode
// - sleep with top bits zero ignores timer and counter-1 time-outs
// - watchdog expiry in sleep resets and restarts at address zero
// - enabled port 7 pin 0, 1, 3 edge in sleep resets device
// - pin 0 wake gated by mask bit 3, edge chosen by core bit 7
// - pin 3 wake gated by mask bit 7, falling edge only
// - pin 1 wake gated by mask bit 4, falling edge only
// - prescaler assigned to watchdog divides by 1 to 128
// - edge select zero gives both edges, one gives falling only
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "cmwd_map.svh"
module cmwd_top #(
  parameter int PLL_LOCK_CYCLES = (`CMWD_PLL_LOCK_US * `CMWD_CLK_MHZ),
  parameter int WDT_TICKS       = (`CMWD_WDT_PERIOD_US * `CMWD_RC_KHZ) / 1000
) (
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire cmwd_pkg::cmwd_osc_t  osc_mode_in,
  input  wire logic                 wdt_rc_clk_in,
  input  wire cmwd_pkg::cmwd_wake_pins_t wake_pins_in,
  input  wire logic                 timer_timeout_in,
  input  wire logic                 counter1_timeout_in,
  output cmwd_pkg::cmwd_cpu_clk_t   cpu_clk_sel_out,
  output logic                      pll_power_out,
  output logic                      sleeping_out,
  output logic                      timer_wake_out,
  output logic                      core_reset_out
);
  if (PLL_LOCK_CYCLES < 1 || PLL_LOCK_CYCLES >= (1 << 20)) begin : g_bad_lock
    $error("bad pll lock count");
  end
  if (WDT_TICKS < 1) begin : g_bad_ticks
    $error("bad watchdog period");
  end

  // synchronised asynchronous inputs
  logic [3:0] sync_q;
  cmwd_sync #(.WIDTH(4)) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({wdt_rc_clk_in, wake_pins_in.p73, wake_pins_in.p71, wake_pins_in.p70}),
    .sync_out   (sync_q)
  );

  // registers and state
  logic [7:0]               ctrl;
  logic [7:0]               core;
  logic [7:0]               mask;
  logic                     sleeping;
  logic [3:0]               prev_q;
  logic [19:0]              lock_cnt;
  cmwd_pkg::cmwd_sw_state_t sw_state;
  logic [1:0]               settle;
  logic [7:0]               next_ctrl;
  logic [7:0]               next_core;
  logic [7:0]               next_mask;
  logic                     next_sleeping;
  logic [3:0]               next_prev_q;
  logic [19:0]              next_lock_cnt;
  cmwd_pkg::cmwd_sw_state_t next_sw_state;
  logic [1:0]               next_settle;
  logic [31:0]              next_prdata;
  logic                     next_pslverr;
  logic                     next_core_reset;

  logic wr;
  logic setup;
  logic settled;
  logic clr_cmd;
  logic slp_cmd;
  logic crystal;
  logic pll_req;
  logic wdt_expire;
  logic rc_tick;
  logic fall70;
  logic rise70;
  logic fall71;
  logic fall73;
  logic pin_wake;

  assign wr      = psel && penable && pwrite;
  assign setup   = psel && !penable;
  assign pready  = 1'b1;
  assign clr_cmd = wr && paddr == `CMWD_ADDR_CMD && pwdata[`CMWD_BIT_CMD_CLEAR];
  assign slp_cmd = wr && paddr == `CMWD_ADDR_CMD && pwdata[`CMWD_BIT_CMD_SLEEP];
  assign crystal = osc_mode_in == cmwd_pkg::CMWD_OSC_CRYSTAL;
  assign pll_req = crystal && ctrl[`CMWD_BIT_PLL_EN];
  // synchroniser comes out of reset at zero; hold edges off until it shows the pins
  assign settled = settle == `CMWD_SYNC_SETTLE;
  assign rc_tick = settled && sync_q[3] && !prev_q[3];
  assign fall70  = settled && prev_q[0] && !sync_q[0];
  assign rise70  = settled && !prev_q[0] && sync_q[0];
  assign fall71  = settled && prev_q[1] && !sync_q[1];
  assign fall73  = settled && prev_q[2] && !sync_q[2];
  assign pin_wake =
      (mask[`CMWD_BIT_MASK_P70] && (fall70 || (!core[`CMWD_BIT_PORT70_EDGE_SELECT] && rise70)))
    || (mask[`CMWD_BIT_MASK_P71] && fall71)
    || (mask[`CMWD_BIT_MASK_P73] && fall73);

  cmwd_wdt #(.CNT_W(16), .TIMEOUT(WDT_TICKS)) u_wdt (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .enable_in  (ctrl[`CMWD_BIT_WDT_EN]),
    .clear_in   (clr_cmd),
    .rc_tick_in (rc_tick),
    .pab_in     (core[`CMWD_BIT_PAB]),
    .psr_in     (core[`CMWD_BIT_PSR_HI:0]),
    .expire_out (wdt_expire)
  );

  // register file, sleep and reset
  always_comb begin
    next_ctrl       = ctrl;
    next_core       = core;
    next_mask       = mask;
    next_sleeping   = sleeping;
    next_prev_q     = sync_q;
    next_prdata     = prdata;
    next_pslverr    = 1'b0;
    next_core_reset = 1'b0;
    next_settle     = settled ? settle : 2'(settle + 2'h1);
    if (wr) begin
      case (paddr)
        `CMWD_ADDR_CTRL: next_ctrl = pwdata[7:0];
        `CMWD_ADDR_CORE: next_core = pwdata[7:0];
        `CMWD_ADDR_MASK: next_mask = pwdata[7:0];
        `CMWD_ADDR_CMD:  next_sleeping = sleeping || slp_cmd;
        default:         ;
      endcase
    end
    // captured in setup so that data and error stand through the zero-wait access
    if (setup) begin
      case (paddr)
        `CMWD_ADDR_CTRL:   next_prdata = {24'h000000, ctrl};
        `CMWD_ADDR_CORE:   next_prdata = {24'h000000, core};
        `CMWD_ADDR_MASK:   next_prdata = {24'h000000, mask};
        `CMWD_ADDR_CMD:    next_prdata = 32'h00000000;
        `CMWD_ADDR_STATUS: begin
          next_prdata  = {28'h0000000, sw_state, pll_power_out, sleeping};
          next_pslverr = pwrite;
        end
        default: begin
          next_prdata  = 32'h00000000;
          next_pslverr = 1'b1;
        end
      endcase
    end
    // only the wdt and pin edges leave this sleep; timer sources are ignored
    if (wdt_expire || (sleeping && pin_wake)) begin
      next_core_reset = 1'b1;
      next_sleeping   = 1'b0;
    end
    if (!rst_n_in) begin
      next_ctrl     = `CMWD_CTRL_RESET;
      next_core     = `CMWD_CORE_RESET;
      next_mask     = `CMWD_MASK_RESET;
      next_sleeping = 1'b0;
      next_prev_q   = 4'h0;
      next_prdata   = 32'h00000000;
      next_pslverr    = 1'b0;
      next_core_reset = 1'b0;
      next_settle     = 2'h0;
    end
  end

  // timer wake is only honoured outside the documented sleep flavour
  assign timer_wake_out = sleeping && (ctrl[`CMWD_BIT_TOP] || ctrl[`CMWD_BIT_PLL_EN])
                          && (timer_timeout_in || counter1_timeout_in);

  // clock switch: hold sub clock until pll count lock elapses
  always_comb begin
    next_sw_state = sw_state;
    next_lock_cnt = lock_cnt;
    case (sw_state)
      cmwd_pkg::CMWD_SW_GREEN: begin
        next_lock_cnt = 20'h00000;
        if (pll_req) next_sw_state = cmwd_pkg::CMWD_SW_WAIT;
      end
      cmwd_pkg::CMWD_SW_WAIT: begin
        if (!pll_req) begin
          next_sw_state = cmwd_pkg::CMWD_SW_GREEN;
        end else if (lock_cnt == 20'(PLL_LOCK_CYCLES - 1)) begin
          next_sw_state = cmwd_pkg::CMWD_SW_NORM;
        end else begin
          next_lock_cnt = 20'(lock_cnt + 20'h00001);
        end
      end
      cmwd_pkg::CMWD_SW_NORM: begin
        if (!pll_req) next_sw_state = cmwd_pkg::CMWD_SW_GREEN;
      end
      default: next_sw_state = cmwd_pkg::CMWD_SW_GREEN;
    endcase
    if (!rst_n_in) begin
      next_sw_state = cmwd_pkg::CMWD_SW_GREEN;
      next_lock_cnt = 20'h00000;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    ctrl           <= next_ctrl;
    core           <= next_core;
    mask           <= next_mask;
    sleeping       <= next_sleeping;
    prev_q         <= next_prev_q;
    prdata         <= next_prdata;
    pslverr        <= next_pslverr;
    core_reset_out <= next_core_reset;
    sw_state       <= next_sw_state;
    lock_cnt       <= next_lock_cnt;
    settle         <= next_settle;
  end

  // rc modes ignore select bits and pll; the switch is glitch-free by state
  always_comb begin
    pll_power_out = pll_req && !sleeping;
    if (sw_state != cmwd_pkg::CMWD_SW_NORM || !pll_req) begin
      cpu_clk_sel_out = cmwd_pkg::CMWD_CPU_SUB;
    end else if (ctrl[`CMWD_BIT_CLKSEL_HI]) begin
      cpu_clk_sel_out = cmwd_pkg::CMWD_CPU_HIGH;
    end else begin
      cpu_clk_sel_out = cmwd_pkg::CMWD_CPU_LOW;
    end
    sleeping_out = sleeping;
  end

  // assertions
  property p_reset_on_expire;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      wdt_expire |=> core_reset_out;
  endproperty
  a_reset_on_expire: assert property (p_reset_on_expire) else $error("no reset on wdt expiry");

  property p_wdt_off;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      !ctrl[`CMWD_BIT_WDT_EN] && !$past(ctrl[`CMWD_BIT_WDT_EN]) |-> !wdt_expire;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("wdt expired while disabled");

  property p_green_when_pll_off;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      !ctrl[`CMWD_BIT_PLL_EN] |-> cpu_clk_sel_out == cmwd_pkg::CMWD_CPU_SUB;
  endproperty
  a_green_when_pll_off: assert property (p_green_when_pll_off) else $error("not on sub clock");

  property p_rc_ignores_pll;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      !crystal |-> !pll_power_out && cpu_clk_sel_out == cmwd_pkg::CMWD_CPU_SUB;
  endproperty
  a_rc_ignores_pll: assert property (p_rc_ignores_pll) else $error("pll used in rc mode");

  property p_high_sel;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      sw_state == cmwd_pkg::CMWD_SW_NORM && pll_req && ctrl[`CMWD_BIT_CLKSEL_HI]
        |-> cpu_clk_sel_out == cmwd_pkg::CMWD_CPU_HIGH;
  endproperty
  a_high_sel: assert property (p_high_sel) else $error("14.3 MHz not chosen");

  sequence s_pll_asked;
    pll_req && sw_state == cmwd_pkg::CMWD_SW_GREEN;
  endsequence
  property p_lock_wait;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_pll_asked |=> cpu_clk_sel_out == cmwd_pkg::CMWD_CPU_SUB;
  endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("switched before pll lock");

  property p_pin_wake;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      sleeping && mask[`CMWD_BIT_MASK_P73] && fall73 |=> core_reset_out && !sleeping;
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("pin 3 did not wake");

  property p_pin1_wake;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      sleeping && mask[`CMWD_BIT_MASK_P71] && fall71 |=> core_reset_out && !sleeping;
  endproperty
  a_pin1_wake: assert property (p_pin1_wake) else $error("pin 1 did not wake");

  property p_timer_no_wake;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      sleeping && ctrl[`CMWD_BIT_TOP:`CMWD_BIT_PLL_EN] == 2'h0 |-> !timer_wake_out;
  endproperty
  a_timer_no_wake: assert property (p_timer_no_wake) else $error("timer woke sleep");
endmodule // cmwd_top
`default_nettype wire

// ===== tb/clock_mode_and_watchdog_bench.sv
// self-checking bench for cmwd_top: apb registers, clock mode, watchdog, sleep wake-up
// assumes cmwd_pkg compiled first; watchdog rc clock runs free and unrelated to clk_sys_in
`timescale 1ns/1ns
`default_nettype none
`include "cmwd_map.svh"
module clock_mode_and_watchdog_bench;
  localparam int LOCK  = 8;
  localparam int TICKS = 3;
  logic                         clk_sys_in = 1'b0;
  logic                         rst_n_in   = 1'b0;
  logic                         psel       = 1'b0;
  logic                         penable    = 1'b0;
  logic                         pwrite     = 1'b0;
  logic [11:0]                  paddr      = 12'h000;
  logic [31:0]                  pwdata     = 32'h0;
  logic [31:0]                  prdata;
  logic                         pready;
  logic                         pslverr;
  cmwd_pkg::cmwd_osc_t          osc        = cmwd_pkg::CMWD_OSC_CRYSTAL;
  logic                         rc_clk     = 1'b0;
  cmwd_pkg::cmwd_wake_pins_t    pins       = 3'h7;
  logic                         tmr_to     = 1'b0;
  logic                         cnt1_to    = 1'b0;
  cmwd_pkg::cmwd_cpu_clk_t      cpu_sel;
  logic                         pll_pwr;
  logic                         sleeping;
  logic                         tmr_wake;
  logic                         core_rst;
  int                           error_cnt   = 0;
  int                           check_count = 0;
  int                           cyc         = 0;
  int                           n;
  int                           t;
  logic [31:0]                  d;
  logic                         e;
  logic [7:0]                   c;
  int                           pidx[9] = '{1, 1, 0, 0, 2, 2, 2, 2, 1};
  logic [7:0]                   msk[9]  = '{8'h10, 8'h00, 8'h80, 8'h80, 8'h08, 8'h08, 8'h08,
                                            8'h00, 8'h10};
  logic [7:0]                   cor[9]  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80,
                                            8'h00, 8'h00};
  bit                           rise[9] = '{0, 0, 0, 1, 1, 1, 0, 0, 1};
  bit                           wake[9] = '{1, 0, 1, 0, 1, 0, 1, 0, 0};

  cmwd_top #(.PLL_LOCK_CYCLES(LOCK), .WDT_TICKS(TICKS)) DUT (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_mode_in(osc), .wdt_rc_clk_in(rc_clk), .wake_pins_in(pins),
    .timer_timeout_in(tmr_to), .counter1_timeout_in(cnt1_to), .cpu_clk_sel_out(cpu_sel),
    .pll_power_out(pll_pwr), .sleeping_out(sleeping), .timer_wake_out(tmr_wake),
    .core_reset_out(core_rst));

  initial forever #50 clk_sys_in = ~clk_sys_in;
  // 940 ns rc period: about 9.4 system cycles per watchdog tick
  initial forever #470 rc_clk = ~rc_clk;

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      test_done;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic do_reset;
    rst_n_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] v,
                     output logic [31:0] rd, output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, v};
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do @(posedge clk_sys_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edge so a following call never re-drives psel in the same step
    @(posedge clk_sys_in);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic [31:0] x;
    logic        y;
    apb(1'b1, a, v, x, y);
  endtask

  task automatic wait_rst(input int lim, output int cnt);
    cnt = 0;
    @(negedge clk_sys_in);
    while (core_rst !== 1'b1 && cnt < lim) begin
      @(negedge clk_sys_in);
      cnt++;
    end
    @(posedge clk_sys_in);
  endtask

  function automatic cmwd_pkg::cmwd_cpu_clk_t exp_clk(cmwd_pkg::cmwd_osc_t o, logic [7:0] r);
    if (o != cmwd_pkg::CMWD_OSC_CRYSTAL || !r[6]) return cmwd_pkg::CMWD_CPU_SUB;
    return r[5] ? cmwd_pkg::CMWD_CPU_HIGH : cmwd_pkg::CMWD_CPU_LOW;
  endfunction

  initial begin
    void'($urandom(48806));
    do_reset;
    apb(1'b0, `CMWD_ADDR_CTRL, 8'h00, d, e);
    chk(d, 32'h00, "ctrl reset");
    apb(1'b0, `CMWD_ADDR_CORE, 8'h00, d, e);
    chk(d, 32'hff, "core reset");
    apb(1'b0, `CMWD_ADDR_MASK, 8'h00, d, e);
    chk(d, 32'h00, "mask reset");
    apb(1'b0, `CMWD_ADDR_STATUS, 8'h00, d, e);
    chk(d, 32'h00, "status reset");
    wr(12'h020, 8'h41);
    apb(1'b0, 12'h020, 8'h00, d, e);
    chk({d[30:0], e}, 32'h1, "unmapped read");
    apb(1'b0, `CMWD_ADDR_CTRL, 8'h00, d, e);
    chk(d, 32'h00, "ctrl after unmapped write");
    $display("test registers done");

    for (int i = 0; i < 8; i++) begin
      c = {2'b01, i[2:0], 3'b000};
      wr(`CMWD_ADDR_CTRL, c);
      @(negedge clk_sys_in);
      chk(pll_pwr, 1'b1, "pll power on");
      chk(cpu_sel, cmwd_pkg::CMWD_CPU_SUB, "sub clock before lock");
      repeat (LOCK + 2) @(negedge clk_sys_in);
      chk(cpu_sel, exp_clk(osc, c), "pll clock select");
      @(posedge clk_sys_in);
      apb(1'b0, `CMWD_ADDR_STATUS, 8'h00, d, e);
      chk(d, 32'h0e, "status normal");
      wr(`CMWD_ADDR_CTRL, c & 8'h38);
      @(negedge clk_sys_in);
      chk({pll_pwr, cpu_sel}, 3'h0, "pll off sub clock");
      @(posedge clk_sys_in);
    end
    for (int i = 1; i < 3; i++) begin
      osc <= cmwd_pkg::cmwd_osc_t'(i);
      c = {2'b01, 3'($urandom), 3'b000};
      wr(`CMWD_ADDR_CTRL, c);
      repeat (LOCK + 2) @(negedge clk_sys_in);
      chk({pll_pwr, cpu_sel}, 3'h0, "rc mode ignores pll and select");
      @(posedge clk_sys_in);
      wr(`CMWD_ADDR_CTRL, 8'h00);
    end
    osc <= cmwd_pkg::CMWD_OSC_CRYSTAL;
    $display("test clock mode done");

    wr(`CMWD_ADDR_CORE, 8'h00);
    wr(`CMWD_ADDR_CMD, 8'h01);
    wait_rst(100, n);
    chk(n, 100, "disabled watchdog quiet");
    wr(`CMWD_ADDR_CTRL, 8'h01);
    for (int k = 0; k < 6; k++) begin
      wr(`CMWD_ADDR_CMD, 8'h01);
      wait_rst(12, n);
      chk(n, 12, "cleared watchdog quiet");
    end
    for (int k = 0; k < 16; k++) begin
      c = {4'h0, k[3], k[2:0]};
      t = TICKS * (k[3] ? (1 << k[2:0]) : 1);
      wr(`CMWD_ADDR_CORE, c);
      wr(`CMWD_ADDR_CTRL, {1'b0, 1'($urandom), 3'($urandom), 3'b001});
      wr(`CMWD_ADDR_CMD, 8'h01);
      wait_rst(t * 10 + 40, n);
      chk(n >= (t - 1) * 9 && n <= t * 10 + 12, 1'b1, "watchdog expiry time");
      wr(`CMWD_ADDR_CTRL, 8'h00);
    end
    $display("test watchdog done");

    do_reset;
    wr(`CMWD_ADDR_CORE, 8'h00);
    wr(`CMWD_ADDR_CTRL, 8'h01);
    wr(`CMWD_ADDR_CMD, 8'h01);
    wr(`CMWD_ADDR_CMD, 8'h02);
    wait_rst(80, n);
    chk(n < 80, 1'b1, "watchdog reset in sleep");
    for (int k = 0; k < 9; k++) begin
      do_reset;
      pins <= 3'h7 ^ (3'(rise[k]) << pidx[k]);
      repeat (5) @(posedge clk_sys_in);
      wr(`CMWD_ADDR_MASK, msk[k]);
      wr(`CMWD_ADDR_CORE, cor[k]);
      wr(`CMWD_ADDR_CTRL, 8'h00);
      wr(`CMWD_ADDR_CMD, 8'h02);
      tmr_to  <= 1'b1;
      cnt1_to <= 1'b1;
      @(negedge clk_sys_in);
      chk({sleeping, tmr_wake}, 2'b10, "asleep, timer wake off");
      @(posedge clk_sys_in);
      tmr_to  <= 1'b0;
      cnt1_to <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      pins <= 3'h7 ^ (3'(!rise[k]) << pidx[k]);
      wait_rst(12, n);
      chk(n < 12, wake[k], "pin wake reset");
      repeat (2) @(negedge clk_sys_in);
      chk(sleeping, !wake[k], "sleep state after pin edge");
      @(posedge clk_sys_in);
      pins <= 3'h7;
    end
    do_reset;
    wr(`CMWD_ADDR_CTRL, 8'h40);
    wr(`CMWD_ADDR_CMD, 8'h02);
    tmr_to <= 1'b1;
    @(negedge clk_sys_in);
    chk({sleeping, tmr_wake}, 2'b11, "timer wake in other sleep");
    @(posedge clk_sys_in);
    tmr_to <= 1'b0;
    $display("test sleep wake done");
    test_done;
  end
endmodule // clock_mode_and_watchdog_bench
`default_nettype wire
